// ---- hw/cbh_pkg.sv ----
// Package of offsets, field positions and reset values for the bridge configuration header.
package cbh_pkg;
	// Configuration dword offsets, as byte addresses of the aligned words.
	localparam logic [7:0] OFF_IDENTITY = 8'h00;
	localparam logic [7:0] OFF_CMD_STAT = 8'h04;
	localparam logic [7:0] OFF_SOCK_BASE = 8'h10;
	localparam logic [7:0] OFF_MEM0_BASE = 8'h1c;
	localparam logic [7:0] OFF_MEM0_LIMIT = 8'h20;
	localparam logic [7:0] OFF_MEM1_BASE = 8'h24;
	localparam logic [7:0] OFF_MEM1_LIMIT = 8'h28;
	localparam logic [7:0] OFF_IO0_BASE = 8'h2c;
	localparam logic [7:0] OFF_IO0_LIMIT = 8'h30;
	localparam logic [7:0] OFF_IO1_BASE = 8'h34;
	localparam logic [7:0] OFF_IO1_LIMIT = 8'h38;
	localparam logic [7:0] OFF_LEGACY_BASE = 8'h44;
	localparam logic [7:0] OFF_SYS_CTRL = 8'h80;
	localparam logic [7:0] OFF_DMA_CARD = 8'h94;
	localparam logic [7:0] OFF_DMA_HOST = 8'h98;
	// Command word fields.
	localparam int CMD_IO_EN = 0;
	localparam int CMD_MEM_EN = 1;
	localparam int CMD_INIT_EN = 2;
	localparam int CMD_PAR_RESP = 6;
	localparam int CMD_SERR_EN = 8;
	localparam logic [15:0] CMD_WRITABLE = 16'h0147;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	// Status word fields.
	localparam int ST_PAR_DET = 15;
	localparam int ST_SERR_SIG = 14;
	localparam int ST_INIT_ABORT = 13;
	localparam int ST_TGT_ABORT_RCV = 12;
	localparam int ST_TGT_ABORT_SIG = 11;
	localparam int ST_DATA_PAR = 8;
	localparam logic [15:0] ST_FIXED = 16'h0200;
	localparam logic [15:0] ST_STICKY_RESET = 16'h0000;
	// Socket register window base keeps only bits 31 to 12.
	localparam logic [31:0] SOCK_BASE_MASK = 32'hffff_f000;
	// Transfer width select field in the host-side DMA setup word.
	localparam int DMA_WIDTH_LSB = 6;
	localparam int DMA_WIDTH_W = 2;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// Arbitrary neutral identity codes.
	localparam logic [15:0] MAKER_ID_DEFAULT = 16'h0a5a;
	localparam logic [15:0] PART_ID_DEFAULT = 16'h5a0a;
endpackage

// ---- hw/cbh_config_header.sv ----
// Configuration header of one bridge device with two socket functions.
`timescale 1ns/1ps
module cbh_config_header #(
	parameter logic [15:0] MAKER_ID = cbh_pkg::MAKER_ID_DEFAULT,
	parameter logic [15:0] PART_ID = cbh_pkg::PART_ID_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cfg_req,
	input wire logic cfg_func,
	input wire logic cfg_write,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire logic mem_hit,
	input wire logic io_hit,
	input wire logic init_want,
	input wire logic data_par_err,
	input wire logic addr_par_err,
	input wire logic perr_seen_as_init,
	input wire logic master_abort,
	input wire logic target_abort_rcvd,
	input wire logic target_abort_sent,
	output logic mem_claim,
	output logic io_claim,
	output logic init_req,
	output logic perr_assert,
	output logic serr_assert,
	output logic [1:0] dma_width,
	output logic mwi_use
);
	logic [15:0] cmd_q;
	logic [15:0] stat_q;
	logic [31:0] win_q [0:1][0:8];
	logic [31:0] legacy_q;
	logic [31:0] sys_ctrl_q;
	logic [31:0] dma_q [0:1][0:1];
	logic [31:0] rd_d;
	logic [15:0] stat_set;
	logic [31:0] cmd_merged;
	logic wr;
	// Status bits that never move: 10 to 9 and the low byte.
	localparam logic [15:0] ST_RO_MASK = 16'h06ff;

	// Byte-lane merge used by every writable word except the write-one-clear status word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Index of a window word, 0 for socket base then 1..8 for the base and limit pairs.
	function automatic logic [3:0] win_idx(input logic [7:0] a);
		case (a)
			cbh_pkg::OFF_SOCK_BASE: win_idx = 4'h0;
			cbh_pkg::OFF_MEM0_BASE: win_idx = 4'h1;
			cbh_pkg::OFF_MEM0_LIMIT: win_idx = 4'h2;
			cbh_pkg::OFF_MEM1_BASE: win_idx = 4'h3;
			cbh_pkg::OFF_MEM1_LIMIT: win_idx = 4'h4;
			cbh_pkg::OFF_IO0_BASE: win_idx = 4'h5;
			cbh_pkg::OFF_IO0_LIMIT: win_idx = 4'h6;
			cbh_pkg::OFF_IO1_BASE: win_idx = 4'h7;
			cbh_pkg::OFF_IO1_LIMIT: win_idx = 4'h8;
			default: win_idx = 4'hf;
		endcase
	endfunction

	// True for every offset that holds a register; all others read as zero.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == cbh_pkg::OFF_IDENTITY) || (a == cbh_pkg::OFF_CMD_STAT)
			|| (win_idx(a) != 4'hf) || (a == cbh_pkg::OFF_LEGACY_BASE)
			|| (a == cbh_pkg::OFF_SYS_CTRL) || (a == cbh_pkg::OFF_DMA_CARD)
			|| (a == cbh_pkg::OFF_DMA_HOST);
	endfunction

	assign wr = cfg_req && cfg_write;

	// The merged word is formed apart, since a function result cannot be sliced directly.
	assign cmd_merged = merge({16'h0000, cmd_q}, cfg_wdata, cfg_be);

	// Command word: one shared copy, only bits 0, 1, 2, 6, 8 storable.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_q <= cbh_pkg::CMD_RESET;
		end else if (wr && cfg_addr == cbh_pkg::OFF_CMD_STAT) begin
			cmd_q <= cmd_merged[15:0] & cbh_pkg::CMD_WRITABLE;
		end
	end

	// Events that set sticky status bits this cycle.
	always_comb begin
		stat_set = 16'h0000;
		stat_set[cbh_pkg::ST_PAR_DET] = data_par_err || addr_par_err;
		stat_set[cbh_pkg::ST_SERR_SIG] = addr_par_err && cmd_q[cbh_pkg::CMD_PAR_RESP]
			&& cmd_q[cbh_pkg::CMD_SERR_EN];
		stat_set[cbh_pkg::ST_INIT_ABORT] = master_abort;
		stat_set[cbh_pkg::ST_TGT_ABORT_RCV] = target_abort_rcvd;
		stat_set[cbh_pkg::ST_TGT_ABORT_SIG] = target_abort_sent;
		stat_set[cbh_pkg::ST_DATA_PAR] = perr_seen_as_init
			&& cmd_q[cbh_pkg::CMD_PAR_RESP];
	end

	// Sticky status: write-one clears, but an event in the same cycle wins.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_q <= cbh_pkg::ST_STICKY_RESET;
		end else if (wr && cfg_addr == cbh_pkg::OFF_CMD_STAT) begin
			stat_q <= (stat_q & ~({cfg_be[3] ? cfg_wdata[31:24] : 8'h00,
				cfg_be[2] ? cfg_wdata[23:16] : 8'h00})) | stat_set;
		end else begin
			stat_q <= stat_q | stat_set;
		end
	end

	// Per-function window and DMA words; the legacy base and system word are shared.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int f = 0; f < 2; f++) begin
				for (int w = 0; w < 9; w++) begin
					win_q[f][w] <= cbh_pkg::WORD_RESET;
				end
				dma_q[f][0] <= cbh_pkg::WORD_RESET;
				dma_q[f][1] <= cbh_pkg::WORD_RESET;
			end
			legacy_q <= cbh_pkg::WORD_RESET;
			sys_ctrl_q <= cbh_pkg::WORD_RESET;
		end else if (wr) begin
			if (win_idx(cfg_addr) == 4'h0) begin
				win_q[cfg_func][0] <= merge(win_q[cfg_func][0], cfg_wdata, cfg_be)
					& cbh_pkg::SOCK_BASE_MASK;
			end else if (win_idx(cfg_addr) != 4'hf) begin
				win_q[cfg_func][win_idx(cfg_addr)] <=
					merge(win_q[cfg_func][win_idx(cfg_addr)], cfg_wdata, cfg_be);
			end
			if (cfg_addr == cbh_pkg::OFF_LEGACY_BASE) begin
				legacy_q <= merge(legacy_q, cfg_wdata, cfg_be);
			end
			if (cfg_addr == cbh_pkg::OFF_SYS_CTRL) begin
				sys_ctrl_q <= merge(sys_ctrl_q, cfg_wdata, cfg_be);
			end
			if (cfg_addr == cbh_pkg::OFF_DMA_CARD) begin
				dma_q[cfg_func][0] <= merge(dma_q[cfg_func][0], cfg_wdata, cfg_be);
			end
			if (cfg_addr == cbh_pkg::OFF_DMA_HOST) begin
				dma_q[cfg_func][1] <= merge(dma_q[cfg_func][1], cfg_wdata, cfg_be);
			end
		end
	end

	// Read decode; any offset not listed returns zero.
	always_comb begin
		rd_d = 32'h0000_0000;
		if (cfg_addr == cbh_pkg::OFF_IDENTITY) begin
			rd_d = {PART_ID, MAKER_ID};
		end else if (cfg_addr == cbh_pkg::OFF_CMD_STAT) begin
			rd_d = {stat_q | cbh_pkg::ST_FIXED, cmd_q};
		end else if (win_idx(cfg_addr) != 4'hf) begin
			rd_d = win_q[cfg_func][win_idx(cfg_addr)];
		end else if (cfg_addr == cbh_pkg::OFF_LEGACY_BASE) begin
			rd_d = legacy_q;
		end else if (cfg_addr == cbh_pkg::OFF_SYS_CTRL) begin
			rd_d = sys_ctrl_q;
		end else if (cfg_addr == cbh_pkg::OFF_DMA_CARD) begin
			rd_d = dma_q[cfg_func][0];
		end else if (cfg_addr == cbh_pkg::OFF_DMA_HOST) begin
			rd_d = dma_q[cfg_func][1];
		end
	end

	// Configuration answers are always given, one cycle after the request.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_ack <= 1'b0;
			cfg_rdata <= cbh_pkg::WORD_RESET;
		end else begin
			cfg_ack <= cfg_req;
			cfg_rdata <= (cfg_req && !cfg_write) ? rd_d : cbh_pkg::WORD_RESET;
		end
	end

	// Target claims and initiator request, each gated by its command bit.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mem_claim <= 1'b0;
			io_claim <= 1'b0;
			init_req <= 1'b0;
			perr_assert <= 1'b0;
			serr_assert <= 1'b0;
			dma_width <= 2'b00;
			mwi_use <= 1'b0;
		end else begin
			mem_claim <= mem_hit && cmd_q[cbh_pkg::CMD_MEM_EN];
			io_claim <= io_hit && cmd_q[cbh_pkg::CMD_IO_EN];
			init_req <= init_want && cmd_q[cbh_pkg::CMD_INIT_EN];
			perr_assert <= data_par_err && cmd_q[cbh_pkg::CMD_PAR_RESP];
			serr_assert <= addr_par_err && cmd_q[cbh_pkg::CMD_PAR_RESP]
				&& cmd_q[cbh_pkg::CMD_SERR_EN];
			dma_width <= dma_q[cfg_func][1][cbh_pkg::DMA_WIDTH_LSB +: cbh_pkg::DMA_WIDTH_W];
			mwi_use <= 1'b0;
		end
	end

	// Claims only follow enabled command bits.
	mem_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		mem_claim |-> $past(cmd_q[cbh_pkg::CMD_MEM_EN]) && $past(mem_hit))
		else $error("memory claim without enable");
	io_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_claim |-> $past(cmd_q[cbh_pkg::CMD_IO_EN]) && $past(io_hit))
		else $error("io claim without enable");
	init_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		init_req |-> $past(cmd_q[cbh_pkg::CMD_INIT_EN]))
		else $error("initiator request while disabled");
	serr_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		serr_assert |-> $past(cmd_q[cbh_pkg::CMD_SERR_EN] && cmd_q[cbh_pkg::CMD_PAR_RESP]))
		else $error("serr without both enables");
	cmd_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cmd_q & ~cbh_pkg::CMD_WRITABLE) == 16'h0000)
		else $error("fixed command bit set");
	par_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
		data_par_err |=> stat_q[cbh_pkg::ST_PAR_DET])
		else $error("parity error not recorded");
	dpar_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(stat_q[cbh_pkg::ST_DATA_PAR]) |-> $past(perr_seen_as_init)
		&& $past(cmd_q[cbh_pkg::CMD_PAR_RESP]))
		else $error("data parity flag without cause");
	abort_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
		master_abort ##1 !wr [*2] |-> stat_q[cbh_pkg::ST_INIT_ABORT])
		else $error("master abort flag lost");
	ack_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
		cfg_req |=> cfg_ack)
		else $error("configuration cycle not answered");

	// A read request and a command word write, as seen at the edge that takes them.
	sequence s_cfg_read;
		cfg_req && !cfg_write;
	endsequence
	sequence s_cmd_write;
		wr && cfg_addr == cbh_pkg::OFF_CMD_STAT;
	endsequence

	// No answer comes without a request, and writes carry no read data.
	ack_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
		!cfg_req |=> !cfg_ack)
		else $error("acknowledge without request");
	wr_rdata_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr |=> cfg_rdata == cbh_pkg::WORD_RESET)
		else $error("write answered with data");

	// Identity words never change, whatever was written.
	ident_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_cfg_read ##0 (cfg_addr == cbh_pkg::OFF_IDENTITY) |=> cfg_rdata == {PART_ID, MAKER_ID})
		else $error("identity word wrong");

	// Hardwired command and status bits read back at their fixed values.
	cmd_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_cfg_read ##0 (cfg_addr == cbh_pkg::OFF_CMD_STAT)
		|=> (cfg_rdata[15:0] & ~cbh_pkg::CMD_WRITABLE) == 16'h0000)
		else $error("fixed command bit read as one");
	stat_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_cfg_read ##0 (cfg_addr == cbh_pkg::OFF_CMD_STAT)
		|=> (cfg_rdata[31:16] & ST_RO_MASK) == cbh_pkg::ST_FIXED)
		else $error("fixed status bits wrong");

	// Holes in the header read as zero.
	reserved_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_cfg_read ##0 !mapped(cfg_addr) |=> cfg_rdata == cbh_pkg::WORD_RESET)
		else $error("reserved offset read nonzero");

	// A one written clears a flag when no new event arrives in the same cycle.
	stat_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_cmd_write ##0 (cfg_be[3] && cfg_wdata[31] && !data_par_err && !addr_par_err)
		|=> !stat_q[cbh_pkg::ST_PAR_DET])
		else $error("status flag not cleared");

	// Without a status write no flag may fall.
	stat_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(wr && cfg_addr == cbh_pkg::OFF_CMD_STAT)
		|=> (stat_q & $past(stat_q)) == $past(stat_q))
		else $error("status flag lost");

	// Every driven system error is recorded.
	serr_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
		serr_assert |-> stat_q[cbh_pkg::ST_SERR_SIG])
		else $error("system error not recorded");

	// Abort events raise their flags on the next edge.
	tabort_rcv_a: assert property (@(posedge ref_clk) disable iff (rst)
		target_abort_rcvd |=> stat_q[cbh_pkg::ST_TGT_ABORT_RCV])
		else $error("received target abort not recorded");
	tabort_sig_a: assert property (@(posedge ref_clk) disable iff (rst)
		target_abort_sent |=> stat_q[cbh_pkg::ST_TGT_ABORT_SIG])
		else $error("signalled target abort not recorded");

	// Address parity errors are detected even with reporting disabled.
	pdet_any_a: assert property (@(posedge ref_clk) disable iff (rst)
		addr_par_err |=> stat_q[cbh_pkg::ST_PAR_DET])
		else $error("address parity error not recorded");

	// The data parity flag cannot rise while the response bit is clear.
	dpar_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		!cmd_q[cbh_pkg::CMD_PAR_RESP] && !stat_q[cbh_pkg::ST_DATA_PAR]
		|=> !stat_q[cbh_pkg::ST_DATA_PAR])
		else $error("data parity flag with response off");

	// Parity reporting follows the response bit both ways.
	perr_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		perr_assert |-> $past(data_par_err) && $past(cmd_q[cbh_pkg::CMD_PAR_RESP]))
		else $error("parity error driven while ignored");
	perr_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		data_par_err && cmd_q[cbh_pkg::CMD_PAR_RESP] |=> perr_assert)
		else $error("data parity error not reported");

	// Enabled decodes must be claimed one cycle later.
	mem_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		mem_hit && cmd_q[cbh_pkg::CMD_MEM_EN] |=> mem_claim)
		else $error("enabled memory cycle not claimed");
	io_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_hit && cmd_q[cbh_pkg::CMD_IO_EN] |=> io_claim)
		else $error("enabled io cycle not claimed");
	init_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		init_want && cmd_q[cbh_pkg::CMD_INIT_EN] |=> init_req)
		else $error("enabled initiator request dropped");

	// A zero command word leaves only configuration cycles answered.
	zero_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
		cmd_q == cbh_pkg::CMD_RESET |=> !mem_claim && !io_claim && !init_req)
		else $error("activity with zero command word");

	// Invalidating writes are never used.
	mwi_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		!mwi_use)
		else $error("invalidating write used");
endmodule

// ---- tb/cbh_host_model.sv ----
// Host bridge model that issues configuration cycles to the header.
`timescale 1ns/1ps
module cbh_host_model (
	input wire logic ref_clk,
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata,
	output logic cfg_req,
	output logic cfg_func,
	output logic cfg_write,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata
);
	// The bus starts quiet so nothing is taken before reset ends.
	initial begin
		{cfg_req, cfg_func, cfg_write, cfg_addr, cfg_be, cfg_wdata} = '0;
	end
	// One request per call; the strobe stays up so calls can run back to back.
	task automatic put(input logic f, w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		@(negedge ref_clk);
		{cfg_req, cfg_func, cfg_write, cfg_addr, cfg_be, cfg_wdata} = {1'b1, f, w, a, b, d};
		@(posedge ref_clk);
	endtask
	// Released lines flip, so a stale address or data word is never mistaken for valid.
	task automatic idle();
		@(negedge ref_clk);
		cfg_req = 1'b0;
		cfg_addr = ~cfg_addr;
		cfg_wdata = ~cfg_wdata;
	endtask
	// Read first and write back only the masked bits, keeping all other settings.
	task automatic rmw(input logic f, input logic [7:0] a, input logic [31:0] m, d);
		logic [31:0] v;
		put(f, 1'b0, a, 4'hf, 32'h0000_0000);
		idle();
		v = cfg_rdata;
		put(f, 1'b1, a, 4'hf, (v & ~m) | (d & m));
		idle();
	endtask
endmodule

// ---- tb/cbh_tb.sv ----
// Self-checking bench for the bridge configuration header.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
	logic ref_clk, rst, cfg_req, cfg_func, cfg_write, cfg_ack, mem_hit, io_hit, init_want;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be, b;
	logic [31:0] cfg_wdata, cfg_rdata, seed, d, exp_v;
	logic [15:0] cmd, st, m;
	logic [5:0] ev;
	logic mem_claim, io_claim, init_req, perr_assert, serr_assert, mwi_use;
	logic [1:0] dma_width;
	logic [31:0] expq[$];
	int fails = 0;
	int n_compared = 0;
	cbh_config_header DUT (.ref_clk(ref_clk), .rst(rst), .cfg_req(cfg_req),
		.cfg_func(cfg_func), .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .mem_hit(mem_hit),
		.io_hit(io_hit), .init_want(init_want), .data_par_err(ev[5]), .addr_par_err(ev[4]),
		.perr_seen_as_init(ev[3]), .master_abort(ev[2]), .target_abort_rcvd(ev[1]),
		.target_abort_sent(ev[0]), .mem_claim(mem_claim), .io_claim(io_claim),
		.init_req(init_req), .perr_assert(perr_assert), .serr_assert(serr_assert),
		.dma_width(dma_width), .mwi_use(mwi_use));
	cbh_host_model host (.ref_clk(ref_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.cfg_req(cfg_req), .cfg_func(cfg_func), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
	// Free-running clock at 125 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Notes the expected answer first, writes expect zero, then the host places it.
	task automatic xfer(input logic f, w, input logic [7:0] a, input logic [3:0] bb,
		input logic [31:0] dd, e);
		expq.push_back(e);
		host.put(f, w, a, bb, dd);
	endtask
	// Checks the gated outputs against the command word, then fires every event once.
	task automatic gates(input logic [15:0] c);
		@(negedge ref_clk);
		`CHK(mem_claim, c[1] & mem_hit)
		`CHK(io_claim, c[0] & io_hit)
		`CHK(init_req, c[2] & init_want)
		`CHK(mwi_use, 1'b0)
		ev = '1;
		@(negedge ref_clk);
		ev = '0;
		`CHK(perr_assert, c[6])
		`CHK(serr_assert, c[6] & c[8])
		st = st | 16'hb800 | {1'b0, c[6] & c[8], 5'b0, c[6], 8'h00};
	endtask
	// Each acknowledge retires the oldest note; an unexpected one meets a marker value.
	always @(negedge ref_clk) begin
		if (cfg_ack === 1'b1) begin
			exp_v = (expq.size() > 0) ? expq.pop_front() : 32'hdead_beef;
			`CHK(cfg_rdata, exp_v)
		end
	end
	// A hung run is cut short and reported as a failure.
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		results();
	end
	// Main sequence: reset state, identity, random command traffic, decode and windows.
	initial begin
		{rst, mem_hit, io_hit, init_want, ev, cmd, st} = {4'hf, 6'h00, 32'h0000_0000};
		seed = 32'hd2d8;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		gates(16'h0000);
		xfer(1, 0, cbh_pkg::OFF_IDENTITY, 4'hf, 0,
			{cbh_pkg::PART_ID_DEFAULT, cbh_pkg::MAKER_ID_DEFAULT});
		xfer(0, 1, cbh_pkg::OFF_IDENTITY, 4'hf, 32'hffff_ffff, 0);
		xfer(0, 0, cbh_pkg::OFF_IDENTITY, 4'hf, 0,
			{cbh_pkg::PART_ID_DEFAULT, cbh_pkg::MAKER_ID_DEFAULT});
		$display("reset and identity test done");
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(lfsr(seed));
			{d, b} = {seed, seed[3:0]};
			m = {{8{b[1]}}, {8{b[0]}}};
			cmd = ((cmd & ~m) | (d[15:0] & m)) & cbh_pkg::CMD_WRITABLE;
			st = st & ~(d[31:16] & {{8{b[3]}}, {8{b[2]}}});
			xfer(i[0], 1, cbh_pkg::OFF_CMD_STAT, b, d, 0);
			host.idle();
			{mem_hit, io_hit, init_want} = seed[6:4];
			gates(cmd);
			xfer(~i[0], 0, cbh_pkg::OFF_CMD_STAT, 4'hf, 0, {st | cbh_pkg::ST_FIXED, cmd});
		end
		xfer(0, 1, cbh_pkg::OFF_CMD_STAT, 4'hf, 32'hffff_0000, 0);
		host.idle();
		{cmd, st} = '0;
		gates(16'h0000);
		$display("command and status test done");
		xfer(1, 1, cbh_pkg::OFF_SYS_CTRL, 4'hf, 32'h1234_5678, 0);
		xfer(0, 0, cbh_pkg::OFF_SYS_CTRL, 4'hf, 0, 32'h1234_5678);
		xfer(0, 1, cbh_pkg::OFF_MEM0_BASE, 4'hf, 32'hffff_ffff, 0);
		xfer(1, 0, cbh_pkg::OFF_MEM0_BASE, 4'hf, 0, 0);
		xfer(0, 1, cbh_pkg::OFF_SOCK_BASE, 4'hf, 32'hffff_ffff, 0);
		xfer(0, 0, cbh_pkg::OFF_SOCK_BASE, 4'hf, 0, cbh_pkg::SOCK_BASE_MASK);
		xfer(0, 1, 8'h48, 4'hf, 32'hffff_ffff, 0);
		xfer(0, 0, 8'h48, 4'hf, 0, 0);
		xfer(0, 0, 8'h9c, 4'hf, 0, 0);
		xfer(0, 1, cbh_pkg::OFF_DMA_HOST, 4'hf, 32'h0000_0080, 0);
		host.idle();
		repeat (2) @(negedge ref_clk);
		`CHK(dma_width, 2'b10)
		expq.push_back(32'h1234_5678);
		expq.push_back(32'h0000_0000);
		host.rmw(1, cbh_pkg::OFF_SYS_CTRL, 32'h0000_00ff, 32'h0000_00aa);
		xfer(0, 0, cbh_pkg::OFF_SYS_CTRL, 4'hf, 0, 32'h1234_56aa);
		host.idle();
		repeat (3) @(negedge ref_clk);
		`CHK(expq.size(), 0)
		$display("shared, window and reserved test done");
		results();
	end
endmodule
